// ### direct_indirect_register_window.v
// Ten-number bus window onto the module register space
`timescale 1ns/1ps
`include "window_regs.vh"
module direct_indirect_register_window #(
  parameter DW = 32
) (
  input  wire                clk_i,       // 10 MHz clock
  input  wire                rstn_i,      // Async reset, active low
  input  wire                rd_i,        // Read request, one cycle
  input  wire                wr_i,        // Write request, one cycle
  input  wire [`BUS_AW-1:0]  addr_i,      // Bus register number 0..9
  input  wire [DW-1:0]       wdata_i,     // Write data
  output reg  [DW-1:0]       rdata_o,     // Read data
  output reg                 rvalid_o,    // Read data valid pulse
  output wire [`MREG_AW-1:0] index_o      // Current index value
);
  reg                       rst_s1_ff;
  reg                       rstn_ff;
  reg  [`MREG_AW-1:0]       index_ff;
  reg                       rd_mem_ff;
  reg  [DW-1:0]             rdirect_ff;
  reg  [DW-1:0]             nxt_rdirect;
  reg                       is_direct;
  reg                       is_index;
  reg                       is_value;
  reg  [2:0]                dsel;
  wire [DW-1:0]             mem_rdata;
  wire [DW*`DIRECT_CNT-1:0] direct_flat;
  wire                      idx_ok;
  wire                      idx_live;
  wire                      mem_we;
  wire                      dir_we;
  wire [`MREG_AW-1:0]       nxt_index;
  genvar                    g;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_ff <= 1'b0;
      rstn_ff   <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rstn_ff   <= rst_s1_ff;
    end
  end

  // Bus number decode
  always @*
  begin
    is_direct = 1'b0;
    is_index  = 1'b0;
    is_value  = 1'b0;
    dsel      = 3'h0;
    if (addr_i >= `BUS_WINDOW)
    begin
      is_direct = 1'b0;
    end
    else if (addr_i <= `ADDR_DIRECT_HI)
    begin
      is_direct = 1'b1;
      dsel      = addr_i[2:0];
    end
    else if (addr_i == `ADDR_INDEX)
    begin
      is_index = 1'b1;
    end
    else if (addr_i == `ADDR_VALUE)
    begin
      is_value = 1'b1;
    end
    else if (addr_i == `ADDR_DIRECT_9)
    begin
      is_direct = 1'b1;
      dsel      = `DIRECT_SEL_9;
    end
    else
    begin
      is_direct = 1'b0;
    end
  end

  assign idx_ok    = (wdata_i[`MREG_AW-1:0] <= `INDEX_MAX) &&
                     (wdata_i[DW-1:`MREG_AW] == {(DW-`MREG_AW){1'b0}});
  assign nxt_index = idx_ok ? wdata_i[`MREG_AW-1:0] : index_ff;
  assign idx_live  = (index_ff >= `INDIRECT_MIN);
  assign mem_we    = wr_i && is_value && idx_live;
  assign dir_we    = wr_i && is_direct;
  assign index_o   = index_ff;

  mreg_store #(
    .DW    (DW),
    .DEPTH (`MREG_COUNT),
    .AW    (`MREG_AW)
  ) u_store (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (index_ff),
    .wdata_i (wdata_i),
    .rdata_o (mem_rdata)
  );

  // direct registers, slot 7 holds number 9
  generate
    for (g = 0; g < `DIRECT_CNT; g = g + 1)
    begin : g_direct
      reg [DW-1:0] val_ff;

      always @(posedge clk_i or negedge rstn_ff)
      begin
        if (!rstn_ff)
        begin
          val_ff <= {DW{1'b0}};
        end
        else if (dir_we && (dsel == g))
        begin
          val_ff <= wdata_i;
        end
      end

      assign direct_flat[g*DW +: DW] = val_ff;
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_ff)
  begin
    if (!rstn_ff)
    begin
      index_ff <= `INDEX_RESET;
    end
    else if (wr_i && is_index)
    begin
      index_ff <= nxt_index;
    end
  end

  always @(posedge clk_i or negedge rstn_ff)
  begin
    if (!rstn_ff)
    begin
      rd_mem_ff <= 1'b0;
      rvalid_o  <= 1'b0;
    end
    else
    begin
      rvalid_o  <= rd_i;
      rd_mem_ff <= rd_i && is_value && idx_live;
    end
  end

  // Read data for everything but the store
  always @*
  begin
    nxt_rdirect = {DW{1'b0}};
    if (is_direct)
    begin
      nxt_rdirect = direct_flat[dsel*DW +: DW];
    end
    else if (is_index)
    begin
      nxt_rdirect = {{(DW-`MREG_AW){1'b0}}, index_ff};
    end
  end

  always @(posedge clk_i or negedge rstn_ff)
  begin
    if (!rstn_ff)
    begin
      rdirect_ff <= {DW{1'b0}};
    end
    else if (rd_i)
    begin
      rdirect_ff <= nxt_rdirect;
    end
  end

  always @*
  begin
    rdata_o = rd_mem_ff ? mem_rdata : rdirect_ff;
  end
endmodule

// ### window_regs.vh
// Constants for the direct and indirect module register window
// Contract
// - Ten thousand module registers, numbered from zero
// - Each direct register bound to one number
// - Direct register reads current, takes writes
// - Numbers 0-6 and 9 direct only
// - Numbers 7, 8, 10-9999 indirect only; the code reaches only 10-9999, and 7 and 8 cannot be accessed at all
// - Indirect access: index then value
// - Value access acts on indexed register
// - Index accepts 0-9999, resets to nine
// - Whole space seen through ten numbers; the code leaves numbers 7 and 8 out
`ifndef WINDOW_REGS_VH
`define WINDOW_REGS_VH
`define MREG_COUNT      10000
`define MREG_AW         14
`define BUS_AW          4
`define BUS_WINDOW      4'hA
`define ADDR_INDEX      4'h7
`define ADDR_VALUE      4'h8
`define ADDR_DIRECT_HI  4'h6
`define ADDR_DIRECT_9   4'h9
`define INDEX_RESET     14'h0009
`define INDEX_MAX       14'h270F
`define INDIRECT_MIN    14'h000A
`define DIRECT_CNT      8
`define DIRECT_SEL_9    3'h7
`endif

// ### mreg_store.v
// Single-port module register store for the indirect space
`timescale 1ns/1ps
module mreg_store #(
  parameter DW    = 32,
  parameter DEPTH = 10000,
  parameter AW    = 14
) (
  input  wire          clk_i,    // Clock
  input  wire          we_i,     // Write strobe
  input  wire [AW-1:0] addr_i,   // Register number
  input  wire [DW-1:0] wdata_i,  // Write data
  output reg  [DW-1:0] rdata_o   // Registered read data
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk_i)
  begin
    if (we_i)
      mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_i];
  end
endmodule

// ### win_chk_sva.sv
// Checker on the register window ports
`timescale 1ns/1ps
module win_chk(input wire clk_i, rstn_i, rd_i, wr_i, rvalid_o,
  input wire [3:0] addr_i, input wire [31:0] wdata_i, rdata_o,
  input wire [13:0] index_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_d9; wr_i && addr_i == 4'h9 ##1 !wr_i ##1 rd_i && addr_i == 4'h9;
  endsequence
  a_rd_ans: assert property (rd_i |=> rvalid_o)
    else $error("rvalid");
  a_rd_only: assert property (!rd_i |=> !rvalid_o)
    else $error("stray");
  a_ix_take: assert property (wr_i && addr_i == 4'h7
    && wdata_i < 32'h2710 |=> {18'h0, index_o} == $past(wdata_i))
    else $error("index");
  a_ix_range: assert property (wr_i && addr_i == 4'h7
    && wdata_i > 32'h270F |=> $stable(index_o)) else $error("range");
  a_ix_hold: assert property (!wr_i |=> $stable(index_o))
    else $error("hold");
  a_ix_read: assert property (rd_i && addr_i == 4'h7 |=>
    rdata_o == {18'h0, $past(index_o)}) else $error("readback");
  a_low_ix: assert property (rd_i && addr_i == 4'h8
    && index_o < 14'hA |=> rdata_o == 32'h0) else $error("low");
  a_dir_rw: assert property (s_d9 |=> rdata_o == $past(wdata_i, 3))
    else $error("direct");
endmodule
bind direct_indirect_register_window win_chk u_chk(.clk_i, .rstn_i, .rd_i,
  .wr_i, .rvalid_o, .addr_i, .wdata_i, .rdata_o, .index_o);

// ### ctl.sv
// Controller model issuing window requests
`timescale 1ns/1ps
module ctl(input wire clk_i, rvalid_i, input wire [31:0] rdata_i,
  output reg rd_o = 0, wr_o = 0, output reg [3:0] addr_o = 0,
  output reg [31:0] wdata_o = 0);
  task wr(input [3:0] a, input [31:0] d);
    @(negedge clk_i) {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i) {wr_o, wdata_o} = {1'b0, ~d};
  endtask
  task rd(input [3:0] a, output [31:0] d);
    d = 'x;
    @(negedge clk_i) {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i)
    begin
      rd_o = 0;
      if (rvalid_i) d = rdata_i;
    end
    repeat (2) @(negedge clk_i) if (rvalid_i) d = rdata_i;
  endtask
endmodule

// ### testbench.sv
// Bench for the register window
`timescale 1ns/1ps
`define CHK(g, e) cmp(g, e)
module testbench;
  reg clk_i = 0, rstn_i = 0;
  wire rd_i, wr_i, rvalid_o;
  wire [3:0] addr_i;
  wire [31:0] wdata_i, rdata_o;
  wire [13:0] index_o;
  logic [31:0] d;
  integer n_fail = 0, check_count = 0, k;
  always #50 clk_i = ~clk_i;
  ctl u_ctl(.clk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o), .rd_o(rd_i),
    .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
  direct_indirect_register_window dut(.*);
  task cmp(input [31:0] g, e);
    check_count++;
    if (g !== e) n_fail++;
    if (g !== e) $display("MISMATCH %0t %h %h", $time, g, e);
  endtask
  task rdc(input [3:0] a, input [31:0] e);
    u_ctl.rd(a, d);
    `CHK(d, e);
  endtask
  task complete_run;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200 rstn_i = 1;
    repeat (3) @(negedge clk_i);
    `CHK(index_o, 14'h0009);
    for (k = 0; k < 10; k++) u_ctl.wr(k[3:0], 32'hA500 + k);
    for (k = 0; k < 10; k++)
      if (k < 7 || k == 9) rdc(k[3:0], 32'hA500 + k);
    rdc(4'h7, 32'h9);
    for (k = 0; k < 4; k++)
    begin
      u_ctl.wr(4'h7, 10 + k[0] * 9989);
      if (k < 2) u_ctl.wr(4'h8, 32'h11 + k);
      else rdc(4'h8, 32'hF + k);
    end
    rdc(4'h8, 32'h12);
    u_ctl.wr(4'h7, 32'h3);
    u_ctl.wr(4'h8, 32'hF);
    rdc(4'h8, 32'h0);
    rdc(4'h3, 32'hA503);
    u_ctl.wr(4'h9, 32'h99);
    rdc(4'h9, 32'h99);
    rdc(4'hC, 32'h0);
    complete_run;
  end
endmodule
